// [sfrdec_pkg.sv]
// package: address map, field positions and reset values for the register space decoder
package sfrdec_pkg;
  // peripheral register space bounds
  localparam logic [7:0] SFRDEC_SPACE_LO    = 8'h80;
  localparam logic [7:0] SFRDEC_SPACE_HI    = 8'hff;
  // register addresses handled here
  localparam logic [7:0] SFRDEC_ADDR_EXTCFG = 8'h85;
  localparam logic [7:0] SFRDEC_ADDR_PAGE   = 8'haa;
  // external memory configuration fields
  localparam int         SFRDEC_FWE_BIT     = 6;
  localparam logic [7:0] SFRDEC_EXTCFG_RO   = 8'h03;
  localparam logic       SFRDEC_FWE_RST     = 1'b0;
  localparam logic [2:0] SFRDEC_PAGE_RST    = 3'h0;
  // external data space windows
  localparam logic [15:0] SFRDEC_WIN_LO     = 16'h0400;
  localparam logic [15:0] SFRDEC_WIN_HI     = 16'h07ff;
  localparam int          SFRDEC_EXTERNAL_DATA_RAM_AW    = 10;
  // usb buffer access: cycles of wait added by the slower domain
  localparam logic [1:0]  SFRDEC_USB_WAIT   = 2'h2;
  // access phase of the external-move sequencer
  typedef enum logic [1:0] {
    SFRDEC_IDLE = 2'b00,
    SFRDEC_WAIT = 2'b01,
    SFRDEC_DONE = 2'b11
  } sfrdec_state_e;
endpackage

// [sfrdec_map_if.sv]
// interface: address map lookup between the decoder top and its map module
`timescale 1ns/1ps
interface sfrdec_map_if;
  logic [7:0] addr;
  logic       in_space;
  logic       bit_ok;
  logic       known;
  modport top (output addr, input in_space, input bit_ok, input known);
  modport map (input addr, output in_space, output bit_ok, output known);
endinterface

// [sfrdec_map.sv]
// module: fixed peripheral register map lookup
`timescale 1ns/1ps
module sfrdec_map (
  sfrdec_map_if.map m
);
  import sfrdec_pkg::*;

  // occupied locations, one bit per address 0x80..0xff, row by row
  localparam logic [127:0] OCCUPIED = {
    8'hff, 8'hff, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hbf, 8'hff,
    8'h7f, 8'hff, 8'hd7, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };

  wire [6:0] idx = m.addr[6:0];

  // decode of the upper range and bit-addressable rows
  assign m.in_space = (m.addr >= SFRDEC_SPACE_LO) && (m.addr <= SFRDEC_SPACE_HI);
  assign m.bit_ok   = m.in_space && (m.addr[2:0] == 3'h0);
  assign m.known    = m.in_space && OCCUPIED[idx];
endmodule

// [sfrdec_top.sv]
// module: peripheral register space decoder with external memory configuration register
`timescale 1ns/1ps
module sfrdec_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  // core register access
  input  wire logic        sfr_valid,
  input  wire logic        sfr_indirect,
  input  wire logic        sfr_write,
  input  wire logic        sfr_bit,
  input  wire logic [2:0]  sfr_bit_pos,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic [7:0]  periph_rdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_ready,
  output logic             periph_sel,
  output logic             uram_sel,
  output logic             bit_refused,
  // external-move access
  input  wire logic        xm_valid,
  input  wire logic        xm_paged,
  input  wire logic [15:0] xm_addr,
  output logic             xm_ready,
  output logic             xm_to_usb,
  output logic [9:0]       xm_ram_addr,
  // state views
  output logic             fifo_window_enable,
  output logic [2:0]       external_data_ram_page_select
);
  import sfrdec_pkg::*;

  // map lookup module and the interface that carries its answers
  sfrdec_map_if mi ();
  sfrdec_map u_map (.m(mi));

  // stored configuration state
  logic          fwe_r;
  logic [2:0]    page_r;

  // external-move sequencer state
  sfrdec_state_e st_r;
  logic [1:0]    wcnt_r;
  logic          usb_hold_r;
  logic [9:0]    ram_addr_hold_r;

  // next values of the sequencer state
  sfrdec_state_e st_nxt;
  logic [1:0]    wcnt_nxt;
  logic          usb_hold_nxt;
  logic [9:0]    ram_addr_hold_nxt;

  // merge a single bit write into a byte
  function automatic logic [7:0] merge_bit(input logic [7:0] old, input logic [2:0] pos,
                                           input logic val);
    logic [7:0] res;
    res      = old;
    res[pos] = val;
    return res;
  endfunction

  // register space decode: direct mode reaches the registers
  assign mi.addr = sfr_addr;
  wire direct     = sfr_valid && !sfr_indirect;
  wire hit        = direct && mi.in_space;

  // indirect mode above 0x7f goes to the upper data ram, never to a register
  wire to_uram    = sfr_valid && sfr_indirect && sfr_addr[7];

  // bit accesses only on aligned rows; any other bit access is refused and dropped
  wire bit_bad    = hit && sfr_bit && !mi.bit_ok;
  wire take       = hit && !bit_bad;

  // selects of the two registers held here and of the other occupied locations
  wire sel_cfg    = take && (sfr_addr == SFRDEC_ADDR_EXTCFG);
  wire sel_page   = take && (sfr_addr == SFRDEC_ADDR_PAGE);
  wire sel_per    = take && mi.known && !sel_cfg && !sel_page;

  // visible bytes; fixed bits come from constants, so no write can reach them
  wire [7:0] cfg_view  = {1'b0, fwe_r, SFRDEC_EXTCFG_RO[5:0]};
  wire [7:0] page_view = {5'h00, page_r};

  // write values; a bit write lands on the visible byte at the given position
  wire [7:0] cfg_wb    = sfr_bit ? merge_bit(cfg_view, sfr_bit_pos, sfr_wdata[0]) : sfr_wdata;
  wire [7:0] page_wb   = sfr_bit ? merge_bit(page_view, sfr_bit_pos, sfr_wdata[0]) : sfr_wdata;

  // read data; writes, reserved and refused accesses answer zero
  wire [7:0] rd_byte   = sel_cfg  ? cfg_view :
                         sel_page ? page_view :
                         sel_per  ? periph_rdata : 8'h00;
  wire [7:0] rd_data   = sfr_bit ? {7'h00, rd_byte[sfr_bit_pos]} : rd_byte;
  wire [7:0] rdata_nxt = (sfr_write || !take) ? 8'h00 : rd_data;

  // next values of the stored bits; only bit 6 and the page bits are kept
  wire       cfg_we   = sfr_write && sel_cfg;
  wire       page_we  = sfr_write && sel_page;
  wire       fwe_nxt  = cfg_we ? cfg_wb[SFRDEC_FWE_BIT] : fwe_r;
  wire [2:0] page_nxt = page_we ? page_wb[2:0] : page_r;

  // configuration registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      fwe_r  <= SFRDEC_FWE_RST;
      page_r <= SFRDEC_PAGE_RST;
    end else begin
      fwe_r  <= fwe_nxt;
      page_r <= page_nxt;
    end
  end

  // register access answer, one cycle after the request
  always_ff @(posedge mclk) begin
    if (reset) begin
      sfr_rdata   <= 8'h00;
      sfr_ready   <= 1'b0;
      periph_sel  <= 1'b0;
      uram_sel    <= 1'b0;
      bit_refused <= 1'b0;
    end else begin
      sfr_rdata   <= rdata_nxt;
      sfr_ready   <= sfr_valid;
      periph_sel  <= sel_per;
      uram_sel    <= to_uram;
      bit_refused <= bit_bad;
    end
  end

  // external-move address: the paged form takes its high byte from the page select
  wire [15:0] xa_paged = {5'h00, page_r, xm_addr[7:0]};
  wire [15:0] xa       = xm_paged ? xa_paged : xm_addr;

  // window decode; while enabled the usb buffer hides the ordinary ram there
  wire        in_win   = (xa >= SFRDEC_WIN_LO) && (xa <= SFRDEC_WIN_HI);
  wire        usb_hit  = fwe_r && in_win;

  // ordinary ram repeats every 1k, so the upper address bits are dropped
  wire [9:0]  ram_addr = xa[SFRDEC_EXTERNAL_DATA_RAM_AW-1:0];

  // sequencer next state; usb window moves wait for the slower domain first
  // requests that arrive while busy are ignored, so the core waits for xm_ready
  always_comb begin
    st_nxt            = st_r;
    wcnt_nxt          = wcnt_r;
    usb_hold_nxt      = usb_hold_r;
    ram_addr_hold_nxt = ram_addr_hold_r;
    unique case (st_r)
      SFRDEC_IDLE: begin
        if (xm_valid) begin
          usb_hold_nxt      = usb_hit;
          ram_addr_hold_nxt = ram_addr;
          wcnt_nxt          = SFRDEC_USB_WAIT;
          st_nxt            = usb_hit ? SFRDEC_WAIT : SFRDEC_DONE;
        end
      end
      SFRDEC_WAIT: begin
        wcnt_nxt = wcnt_r - 2'h1;
        if (wcnt_r == 2'h1) begin
          st_nxt = SFRDEC_DONE;
        end
      end
      SFRDEC_DONE: begin
        st_nxt = SFRDEC_IDLE;
      end
      default: begin
        st_nxt = SFRDEC_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r            <= SFRDEC_IDLE;
      wcnt_r          <= 2'h0;
      usb_hold_r      <= 1'b0;
      ram_addr_hold_r <= 10'h000;
    end else begin
      st_r            <= st_nxt;
      wcnt_r          <= wcnt_nxt;
      usb_hold_r      <= usb_hold_nxt;
      ram_addr_hold_r <= ram_addr_hold_nxt;
    end
  end

  // move completion seen by the output registers
  wire        xm_done  = (st_r == SFRDEC_DONE);

  // external-move outputs registered
  always_ff @(posedge mclk) begin
    if (reset) begin
      xm_ready    <= 1'b0;
      xm_to_usb   <= 1'b0;
      xm_ram_addr <= 10'h000;
    end else begin
      xm_ready    <= xm_done;
      xm_to_usb   <= xm_done && usb_hold_r;
      xm_ram_addr <= ram_addr_hold_r;
    end
  end

  // state views
  always_ff @(posedge mclk) begin
    if (reset) begin
      fifo_window_enable <= 1'b0;
      external_data_ram_page_select   <= 3'h0;
    end else begin
      fifo_window_enable <= fwe_r;
      external_data_ram_page_select   <= page_r;
    end
  end
endmodule

// [sfrdec_top_props.sv]
// checker: concurrent properties for the register space decoder
`timescale 1ns/1ps
module sfrdec_top_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        sfr_valid,
  input wire logic        sfr_indirect,
  input wire logic        sfr_write,
  input wire logic        sfr_bit,
  input wire logic        xm_valid,
  input wire logic        xm_paged,
  input wire logic        sfr_ready,
  input wire logic        periph_sel,
  input wire logic        uram_sel,
  input wire logic        bit_refused,
  input wire logic        xm_ready,
  input wire logic        xm_to_usb,
  input wire logic        fifo_window_enable,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  periph_rdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic [15:0] xm_addr,
  input wire logic [9:0]  xm_ram_addr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // request classes seen by the properties
  wire       dir  = sfr_valid && !sfr_indirect;
  wire       rd   = dir && !sfr_write && !sfr_bit;
  wire       al   = sfr_addr[2:0] == 3'h0;
  wire       win  = xm_addr[15:10] == 6'h01;
  wire [9:0] xlo  = xm_addr[9:0];
  // a config write one cycle earlier is not yet seen on the enable view
  wire       cfg_wr = dir && sfr_write && sfr_addr == 8'h85;
  property p_ready; sfr_valid |=> sfr_ready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after request");
  property p_per; rd && sfr_addr == 8'h80 |=> periph_sel && sfr_rdata == $past(periph_rdata);
  endproperty
  a_per: assert property (p_per) else $error("peripheral read not passed");
  property p_cfg; rd && sfr_addr == 8'h85 |=> sfr_rdata == {1'b0, fifo_window_enable, 6'h03};
  endproperty
  a_cfg: assert property (p_cfg) else $error("config read wrong");
  property p_fwe; dir && sfr_write && !sfr_bit && sfr_addr == 8'h85
    |=> ##1 fifo_window_enable == $past(sfr_wdata[6], 2); endproperty
  a_fwe: assert property (p_fwe) else $error("window enable not written");
  property p_ind; sfr_valid && sfr_indirect && sfr_addr[7] |=> uram_sel && !periph_sel;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect access misrouted");
  property p_bit; sfr_valid && sfr_bit && !sfr_indirect && sfr_addr[7]
    |=> bit_refused == !$past(al); endproperty
  a_bit: assert property (p_bit) else $error("bit access alignment wrong");
  property p_res; dir && sfr_addr == 8'hab |=> sfr_rdata == 8'h00 && !periph_sel;
  endproperty
  a_res: assert property (p_res) else $error("reserved access not dropped");
  property p_ram; xm_valid && !xm_paged && !fifo_window_enable && !$past(cfg_wr)
    |=> !xm_ready ##1 xm_ready && !xm_to_usb && xm_ram_addr == $past(xlo, 2); endproperty
  a_ram: assert property (p_ram) else $error("ram move wrong");
  property p_usb; xm_valid && !xm_paged && fifo_window_enable && win && !$past(cfg_wr)
    |=> !xm_ready [*3] ##1 xm_ready && xm_to_usb; endproperty
  a_usb: assert property (p_usb) else $error("usb window move wrong");
  c_usb: cover property (xm_ready && xm_to_usb);
  c_bit: cover property (bit_refused);
  c_ind: cover property (uram_sel);
endmodule
bind sfrdec_top sfrdec_top_props sfrdec_top_props_i (.mclk, .reset, .sfr_valid, .sfr_indirect,
  .sfr_write, .sfr_bit, .xm_valid, .xm_paged, .sfr_ready, .periph_sel, .uram_sel, .bit_refused,
  .xm_ready, .xm_to_usb, .fifo_window_enable, .sfr_addr, .sfr_wdata, .periph_rdata, .sfr_rdata,
  .xm_addr, .xm_ram_addr);

// [sfrdec_periph_model.sv]
// partner: other peripheral registers answering reads in the same cycle
`timescale 1ns/1ps
module sfrdec_periph_model (
  input wire logic [7:0] addr,
  output logic     [7:0] rdata
);
  // each register shows a value derived from its address
  assign rdata = addr ^ 8'h5a;
endmodule

// [tb.sv]
// testbench: register and external-move sequences against the decoder
`timescale 1ns/1ps
module tb;
  logic        mclk = 0, reset = 1, sfr_valid = 0, sfr_indirect = 0, sfr_write = 0;
  logic        sfr_bit = 0, xm_valid = 0, xm_paged = 0;
  logic        sfr_ready, periph_sel, uram_sel, bit_refused, xm_ready, xm_to_usb;
  logic        fifo_window_enable;
  logic [2:0]  sfr_bit_pos = 3'h0, external_data_ram_page_select;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, periph_rdata, sfr_rdata;
  logic [15:0] xm_addr = 16'h0000;
  logic [9:0]  xm_ram_addr;
  int          mismatches = 0, n_compared = 0, cyc = 0, i, n;
  sfrdec_top sfrdec_top_i (.mclk, .reset, .sfr_valid, .sfr_indirect, .sfr_write, .sfr_bit,
    .sfr_bit_pos, .sfr_addr, .sfr_wdata, .periph_rdata, .sfr_rdata, .sfr_ready, .periph_sel,
    .uram_sel, .bit_refused, .xm_valid, .xm_paged, .xm_addr, .xm_ready, .xm_to_usb,
    .xm_ram_addr, .fifo_window_enable, .external_data_ram_page_select);
  sfrdec_periph_model sfrdec_periph_model_i (.addr(sfr_addr), .rdata(periph_rdata));
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one register request, answer sampled in the cycle in which it stands
  task automatic acc(logic ind, wr, bt, logic [2:0] p, logic [7:0] a, d);
    @(negedge mclk);
    {sfr_valid, sfr_indirect, sfr_write, sfr_bit, sfr_bit_pos, sfr_addr, sfr_wdata}
      = {1'b1, ind, wr, bt, p, a, d};
    @(negedge mclk);
    sfr_valid = 0;
    chk("ready", sfr_ready, 1'b1);
  endtask
  // one external move, latency counted in cycles
  task automatic xm(logic pg, logic [15:0] a, logic usb, logic [9:0] ra);
    @(negedge mclk);
    {xm_valid, xm_paged, xm_addr} = {1'b1, pg, a};
    @(negedge mclk);
    xm_valid = 0;
    n = 1;
    while (xm_ready !== 1'b1 && n < 9) begin
      @(negedge mclk);
      n++;
    end
    chk("xm_lat", 16'(n), usb ? 16'h4 : 16'h2);
    chk("xm_usb", xm_to_usb, usb);
    chk("xm_addr", xm_ram_addr, ra);
  endtask
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge mclk);
    reset = 0;
    acc(0, 0, 0, 0, 8'h85, 0);
    chk("cfg_rst", sfr_rdata, 8'h03);
    chk("fwe_rst", fifo_window_enable, 1'b0);
    acc(0, 1, 1, 6, 8'h85, 1);
    chk("bit_wr", bit_refused, 1'b1);
    acc(0, 1, 0, 0, 8'h85, 8'hff);
    acc(0, 0, 0, 0, 8'h85, 0);
    chk("cfg_on", sfr_rdata, 8'h43);
    chk("fwe_on", fifo_window_enable, 1'b1);
    acc(0, 1, 0, 0, 8'haa, 8'hfd);
    acc(0, 0, 0, 0, 8'haa, 0);
    chk("page", sfr_rdata, 8'h05);
    chk("page_sel", external_data_ram_page_select, 3'h5);
    acc(0, 0, 0, 0, 8'h80, 0);
    chk("periph", {periph_sel, sfr_rdata}, 9'h1da);
    acc(0, 0, 0, 0, 8'ha3, 0);
    chk("periph_a3", {periph_sel, sfr_rdata}, 9'h1f9);
    acc(0, 0, 0, 0, 8'had, 0);
    chk("resv_ad", {periph_sel, sfr_rdata}, 9'h000);
    acc(1, 0, 0, 0, 8'h80, 0);
    chk("uram", {uram_sel, periph_sel}, 2'b10);
    // deliberate touch of a reserved location
    acc(0, 1, 0, 0, 8'hab, 8'hff);
    acc(0, 0, 0, 0, 8'hab, 0);
    chk("resv", {periph_sel, sfr_rdata}, 9'h000);
    for (i = 0; i < 8; i++) begin
      acc(0, 0, 1, 3'h1, 8'hb8 + 8'(i), 0);
      chk("bit_ref", bit_refused, i != 0);
      chk("bit_rd", sfr_rdata, 8'(i == 0));
    end
    // window moves inside and outside the window, direct and paged, then with the window disabled
    xm(0, 16'h0401, 1, 10'h001);
    xm(0, 16'h0bff, 0, 10'h3ff);
    xm(1, 16'h0010, 1, 10'h110);
    acc(0, 1, 0, 0, 8'haa, 8'h00);
    xm(1, 16'h00ff, 0, 10'h0ff);
    acc(0, 1, 0, 0, 8'h85, 8'h00);
    xm(0, 16'h07ff, 0, 10'h3ff);
    summarize();
  end
endmodule
